// ### src/wake_event_control.sv
module wake_event_control #(
  parameter int ADDR_W = 8
) (
  input  logic              clk,
  input  logic              nrst,
  input  logic              nporRst,
  input  logic              ce,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  input  logic              linkUp,
  input  logic              rxValid,
  input  logic [7:0]        rxData,
  input  logic              rxFirst,
  input  logic              rxGoodEnd,
  input  logic              remoteWakeFrame,
  input  logic              cfgPmEnable,
  input  logic              cfgWolEnable,
  input  logic              pmEventClear,
  output logic              pmEventStatus,
  output logic              irq
);
  localparam int NP = wec_pkg::NUM_PAT;
  localparam int IW = wec_pkg::IRQ_W;

  typedef struct packed {
    logic [NP-1:0]                        patEn;
    logic                                 crcSel;
    logic                                 linkDnEn;
    logic                                 linkUpEn;
    logic                                 wake_frame_event_enable;
    logic                                 remote_wake_frame_enable;
    logic                                 link_change_event_enable;
    logic [2:0]                           flags;
    logic                                 pme;
    logic [4:0]                           idx;
    logic [wec_pkg::PAT_WORDS-1:0][31:0]  mem;
    logic                                 linkPrev;
    logic [IW-1:0]                        irqSt;
    logic [IW-1:0]                        irqMask;
    logic                                 irq;
    logic                                 awHeld;
    logic                                 wHeld;
    logic [ADDR_W-1:0]                    awAddr;
    logic [31:0]                          wData;
    logic [3:0]                           wStrb;
    logic                                 awRdy;
    logic                                 wRdy;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 arRdy;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
  } wec_state_t;

  wec_state_t s_r;
  wec_state_t s_nxt;
  wec_state_t porVal;
  wec_state_t hwVal;

  logic [NP-1:0]  hitVec;
  logic           linkRise;
  logic           linkFall;
  logic           linkEvt;
  logic           wakeEvt;
  logic           pmeEvt;
  logic           wrFire;
  logic           patWr;
  logic [31:0]    wrMask;
  logic [31:0]    merged;
  logic [2:0]     flagClr;
  logic [IW-1:0]  istClr;
  logic [IW-1:0]  evVec;
  logic           matchRst;

  // control/status word as software sees it
  function automatic logic [31:0] ctlWord(input wec_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[wec_pkg::BIT_CRCSEL] = s.crcSel;
    w[wec_pkg::BIT_PATEN -: NP] = s.patEn;
    w[wec_pkg::BIT_LINKDN] = s.linkDnEn;
    w[wec_pkg::BIT_LINKUP] = s.linkUpEn;
    w[wec_pkg::BIT_WAKE_FRAME_EVENT_ENABLE] = s.wake_frame_event_enable;
    w[wec_pkg::BIT_REMOTE_WAKE_FRAME_ENABLE] = s.remote_wake_frame_enable;
    w[wec_pkg::BIT_LINK_CHANGE_EVENT_ENABLE] = s.link_change_event_enable;
    w[wec_pkg::BIT_WFR] = s.flags[2];
    w[wec_pkg::BIT_RWF] = s.flags[1];
    w[wec_pkg::BIT_LSC] = s.flags[0];
    return w;
  endfunction

  // byte enables to a bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // receive stream shared by all matchers
  wec_rx_if rxBus ();
  assign rxBus.rxValid = rxValid;
  assign rxBus.rxFirst = rxFirst;
  assign rxBus.rxEnd   = rxGoodEnd;
  assign rxBus.rxByte  = rxData;
  assign rxBus.crcInit = s_r.crcSel;
  assign matchRst      = nrst & nporRst;

  // one matcher per pattern block
  for (genvar i = 0; i < NP; i++) begin : g_pat
    localparam int B = i * wec_pkg::PAT_STRIDE;
    wec_crc_match #(
      .MASK_BITS (wec_pkg::MASK_BITS),
      .POS_W     (wec_pkg::POS_W)
    ) u_match (
      .clk     (clk),
      .nrst    (matchRst),
      .ce      (ce),
      .rx      (rxBus.sink),
      .mask    ({s_r.mem[B+3], s_r.mem[B+2], s_r.mem[B+1], s_r.mem[B]}),
      // crc high half, offset low byte
      .crcRef  (s_r.mem[B+4][wec_pkg::CRC_MSB:wec_pkg::CRC_LSB]),
      .byteOfs (s_r.mem[B+4][wec_pkg::BOFS_MSB:0]),
      .hit     (hitVec[NP-1-i])
    );
  end

  // reset images: power-up clears all but the remote wake enable, hardware reset keeps the flags and pme
  always_comb begin
    porVal = '0;
    porVal.remote_wake_frame_enable = cfgPmEnable & cfgWolEnable;
    hwVal = porVal;
    hwVal.flags = s_r.flags;
    hwVal.pme = s_r.pme;
  end

  // events, register bus and status
  always_comb begin
    s_nxt = s_r;
    flagClr = 3'h0;
    istClr = '0;
    merged = 32'h0000_0000;
    patWr = 1'b0;
    linkRise = !s_r.linkPrev && linkUp;
    linkFall = s_r.linkPrev && !linkUp;
    s_nxt.linkPrev = linkUp;
    linkEvt = (linkRise && s_r.linkUpEn) || (linkFall && s_r.linkDnEn);
    wakeEvt = |(hitVec & s_r.patEn);
    pmeEvt = (s_r.wake_frame_event_enable && wakeEvt) || (s_r.remote_wake_frame_enable && remoteWakeFrame) || (s_r.link_change_event_enable && linkEvt);

    // write address and data, either order
    if (awvalid && s_r.awRdy) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && s_r.wRdy) begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wrFire = s_nxt.awHeld && s_nxt.wHeld && !s_nxt.bvalid;
    wrMask = strbMask(s_nxt.wStrb);

    // register write decode
    if (wrFire) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wec_pkg::RESP_OKAY;
      if (s_nxt.awAddr == ADDR_W'(wec_pkg::OFS_CTL)) begin
        merged = (ctlWord(s_r) & ~wrMask) | (s_nxt.wData & wrMask);
        s_nxt.crcSel = merged[wec_pkg::BIT_CRCSEL];
        s_nxt.patEn = merged[wec_pkg::BIT_PATEN -: NP];
        s_nxt.linkDnEn = merged[wec_pkg::BIT_LINKDN];
        s_nxt.linkUpEn = merged[wec_pkg::BIT_LINKUP];
        s_nxt.wake_frame_event_enable = merged[wec_pkg::BIT_WAKE_FRAME_EVENT_ENABLE];
        s_nxt.remote_wake_frame_enable = merged[wec_pkg::BIT_REMOTE_WAKE_FRAME_ENABLE];
        s_nxt.link_change_event_enable = merged[wec_pkg::BIT_LINK_CHANGE_EVENT_ENABLE];
        flagClr = s_nxt.wData[2:0] & wrMask[2:0];
      end else if (s_nxt.awAddr == ADDR_W'(wec_pkg::OFS_PAT)) begin
        patWr = 1'b1;
        s_nxt.mem[s_r.idx] = (s_r.mem[s_r.idx] & ~wrMask) | (s_nxt.wData & wrMask);
        s_nxt.idx = (s_r.idx == wec_pkg::IDX_LAST) ? wec_pkg::IDX_RST : 5'(s_r.idx + 5'h01);
      end else if (s_nxt.awAddr == ADDR_W'(wec_pkg::OFS_IST)) begin
        istClr = s_nxt.wData[IW-1:0] & wrMask[IW-1:0];
      end else if (s_nxt.awAddr == ADDR_W'(wec_pkg::OFS_IMSK)) begin
        s_nxt.irqMask = s_nxt.wData[IW-1:0] & wrMask[IW-1:0] | s_r.irqMask & ~wrMask[IW-1:0];
      end else begin
        s_nxt.bresp = wec_pkg::RESP_SLVERR;
      end
    end
    s_nxt.awRdy = !s_nxt.awHeld && !s_nxt.bvalid;
    s_nxt.wRdy = !s_nxt.wHeld && !s_nxt.bvalid;

    // read channel, one outstanding
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arRdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = wec_pkg::RESP_OKAY;
      if (araddr == ADDR_W'(wec_pkg::OFS_CTL)) begin
        s_nxt.rdata = ctlWord(s_r);
      end else if (araddr == ADDR_W'(wec_pkg::OFS_PAT)) begin
        s_nxt.rdata = s_r.mem[s_r.idx];
      end else if (araddr == ADDR_W'(wec_pkg::OFS_IST)) begin
        s_nxt.rdata = {{(32-IW){1'b0}}, s_r.irqSt};
      end else if (araddr == ADDR_W'(wec_pkg::OFS_IMSK)) begin
        s_nxt.rdata = {{(32-IW){1'b0}}, s_r.irqMask};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = wec_pkg::RESP_SLVERR;
      end
    end
    s_nxt.arRdy = !s_nxt.rvalid;

    // sticky flags, set wins over clear
    // wake frame, remote wake and link change flags
    s_nxt.flags = (s_r.flags & ~flagClr) | {wakeEvt, remoteWakeFrame, linkEvt};
    s_nxt.pme = (s_r.pme && !pmEventClear) || pmeEvt;

    // interrupt status, mask and line
    evVec = '0;
    evVec[wec_pkg::IRQ_LSC] = linkEvt;
    evVec[wec_pkg::IRQ_RWF] = remoteWakeFrame;
    evVec[wec_pkg::IRQ_WFR] = wakeEvt;
    evVec[wec_pkg::IRQ_PME] = pmeEvt;
    s_nxt.irqSt = (s_r.irqSt & ~istClr) | evVec;
    s_nxt.irq = |(s_nxt.irqSt & s_nxt.irqMask);
  end

  // state register with both resets
  always_ff @(posedge clk) begin
    if (!nporRst) begin
      s_r <= porVal;
    end else if (!nrst) begin
      s_r <= hwVal;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign awready       = s_r.awRdy;
  assign wready        = s_r.wRdy;
  assign bvalid        = s_r.bvalid;
  assign bresp         = s_r.bresp;
  assign arready       = s_r.arRdy;
  assign rvalid        = s_r.rvalid;
  assign rresp         = s_r.rresp;
  assign rdata         = s_r.rdata;
  assign pmEventStatus = s_r.pme;
  assign irq           = s_r.irq;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !nporRst);

  sequence ctlW1cWfr;
    ce && wrFire && s_nxt.awAddr == ADDR_W'(wec_pkg::OFS_CTL) && flagClr[2];
  endsequence

  sequence wakeToPme;
    ce && s_r.wake_frame_event_enable && wakeEvt;
  endsequence

  chk_pattern_gate: assert property (
    $rose(s_r.flags[2]) |-> $past(wakeEvt))
    else $error("wake flag set without enabled match");

  chk_link_down: assert property (
    ce && s_r.linkDnEn && s_r.linkPrev && !linkUp |=> s_r.flags[0])
    else $error("link down not flagged");

  chk_link_up: assert property (
    ce && s_r.linkUpEn && !s_r.linkPrev && linkUp |=> s_r.flags[0] && s_r.linkPrev)
    else $error("link up not flagged");

  chk_wake_pme: assert property (
    wakeToPme |=> s_r.pme && s_r.flags[2])
    else $error("wake match did not raise pm event");

  chk_link_pme: assert property (
    ce && s_r.link_change_event_enable && linkEvt |=> s_r.pme)
    else $error("link change did not raise pm event");

  chk_wfr_clear: assert property (
    ctlW1cWfr ##0 !wakeEvt |=> !s_r.flags[2])
    else $error("wake flag not cleared by write one");

  chk_hw_rst_keep: assert property (
    @(posedge clk) disable iff (!nporRst)
    !nrst |=> s_r.flags == $past(s_r.flags))
    else $error("flags lost on hardware reset");

  chk_pat_store: assert property (
    ce && patWr && wrMask == 32'hFFFF_FFFF |=> s_r.mem[$past(s_r.idx)] == $past(s_nxt.wData))
    else $error("pattern word not stored");

  chk_index_step: assert property (
    ce && patWr |=> s_r.idx == (($past(s_r.idx) == wec_pkg::IDX_LAST) ? wec_pkg::IDX_RST
                                : 5'($past(s_r.idx) + 5'h01)))
    else $error("pattern index did not advance");
endmodule

// ### src/wec_pkg.sv
package wec_pkg;
  // pattern table geometry
  localparam int NUM_PAT    = 5;
  localparam int PAT_STRIDE = 5;
  localparam int PAT_WORDS  = 25;
  localparam int MASK_BITS  = 128;
  localparam int POS_W      = 9;
  localparam int ADDR_W     = 8;
  localparam logic [4:0] IDX_RST  = 5'h00;
  localparam logic [4:0] IDX_LAST = 5'h18;
  // register byte offsets
  localparam logic [7:0] OFS_CTL  = 8'h68;
  localparam logic [7:0] OFS_PAT  = 8'h70;
  localparam logic [7:0] OFS_IST  = 8'h88;
  localparam logic [7:0] OFS_IMSK = 8'h8C;
  // control/status field positions
  localparam int BIT_CRCSEL  = 30;
  localparam int BIT_PATEN   = 29;
  localparam int BIT_LINKDN  = 17;
  localparam int BIT_LINKUP  = 16;
  localparam int BIT_WAKE_FRAME_EVENT_ENABLE    = 10;
  localparam int BIT_REMOTE_WAKE_FRAME_ENABLE    = 9;
  localparam int BIT_LINK_CHANGE_EVENT_ENABLE    = 8;
  localparam int BIT_WFR     = 2;
  localparam int BIT_RWF     = 1;
  localparam int BIT_LSC     = 0;
  // fifth word of a pattern block
  localparam int CRC_LSB = 16;
  localparam int CRC_MSB = 31;
  localparam int BOFS_MSB = 7;
  // crc engine
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  localparam logic [15:0] CRC_INIT_ZERO = 16'h0000;
  localparam logic [15:0] CRC_INIT_ONE  = 16'hFFFF;
  // interrupt status layout
  localparam int IRQ_W   = 4;
  localparam int IRQ_LSC = 0;
  localparam int IRQ_RWF = 1;
  localparam int IRQ_WFR = 2;
  localparam int IRQ_PME = 3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/wec_rx_if.sv
interface wec_rx_if;
  logic       rxValid;
  logic       rxFirst;
  logic       rxEnd;
  logic       crcInit;
  logic [7:0] rxByte;
  modport src  (output rxValid, rxFirst, rxEnd, crcInit, rxByte);
  modport sink (input  rxValid, rxFirst, rxEnd, crcInit, rxByte);
endinterface

// ### src/wec_crc_match.sv
module wec_crc_match #(
  parameter int MASK_BITS = 128,
  parameter int POS_W     = 9
) (
  input  logic                 clk,
  input  logic                 nrst,
  input  logic                 ce,
  wec_rx_if.sink               rx,
  input  logic [MASK_BITS-1:0] mask,
  input  logic [15:0]          crcRef,
  input  logic [7:0]           byteOfs,
  output logic                 hit
);
  localparam logic [POS_W-1:0] WIN     = POS_W'(MASK_BITS);
  localparam logic [POS_W-1:0] POS_MAX = '1;

  typedef struct packed {
    logic [POS_W-1:0] pos;
    logic [15:0]      crc;
    logic             hit;
  } wec_match_t;

  wec_match_t s_r;
  wec_match_t s_nxt;
  logic [POS_W-1:0] curPos;
  logic [POS_W-1:0] rel;
  logic [15:0]      crcV;

  // one byte through the crc, msb first
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ wec_pkg::CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // byte position, masked crc and end-of-frame compare
  always_comb begin
    s_nxt = s_r;
    s_nxt.hit = 1'b0;
    curPos = rx.rxFirst ? '0 : s_r.pos;
    rel = curPos - POS_W'(byteOfs);
    crcV = rx.rxFirst ? (rx.crcInit ? wec_pkg::CRC_INIT_ONE : wec_pkg::CRC_INIT_ZERO) : s_r.crc;
    if (rx.rxValid) begin
      if (curPos >= POS_W'(byteOfs) && rel < WIN && mask[rel[6:0]]) begin
        crcV = crcByte(crcV, rx.rxByte);
      end
      s_nxt.pos = (curPos == POS_MAX) ? curPos : POS_W'(curPos + 1'b1);
    end
    s_nxt.crc = crcV;
    if (rx.rxEnd) begin
      s_nxt.hit = (crcV == crcRef);
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign hit = s_r.hit;
endmodule

// ### sim/wec_rx_model.sv
// receive path and link logic seen from the wake block
module wec_rx_model (
  input  logic       clk,
  output logic       linkUp,
  output logic       rxValid,
  output logic [7:0] rxData,
  output logic       rxFirst,
  output logic       rxGoodEnd,
  output logic       remoteWakeFrame
);
  timeunit 1ns;
  timeprecision 1ps;
  bit busy;
  // quiet outputs at time zero
  initial begin
    busy = 1'b0;
    linkUp = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    rxFirst = 1'b0;
    rxGoodEnd = 1'b0;
    remoteWakeFrame = 1'b0;
  end
  // idle data toggles so a stale byte never looks like a held one
  always @(posedge clk) begin
    if (!busy) rxData <= ~rxData;
  end
  // link level change, one edge later
  task automatic set_link(input logic v);
    @(posedge clk);
    linkUp <= v;
  endtask
  // one-cycle remote wake indication
  task automatic remote_pulse();
    @(posedge clk);
    remoteWakeFrame <= 1'b1;
    @(posedge clk);
    remoteWakeFrame <= 1'b0;
  endtask
  // back-to-back bytes, good end flagged with the last byte
  task automatic send_frame(input logic [7:0] f [8]);
    busy = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rxValid <= 1'b1;
      rxFirst <= (i == 0);
      rxGoodEnd <= (i == 7);
      rxData <= f[i];
    end
    @(posedge clk);
    rxValid <= 1'b0;
    rxFirst <= 1'b0;
    rxGoodEnd <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

// ### sim/wake_event_control_bench.sv
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin nMismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module wake_event_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, nporRst, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pmEventStatus, irq;
  logic        cfgPmEnable, cfgWolEnable, pmEventClear;
  logic        linkUp, rxValid, rxFirst, rxGoodEnd, remoteWakeFrame;
  logic [7:0]  awaddr, araddr, rxData;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] pat [25];
  logic [7:0]  frm [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
  logic [15:0] crc;
  int          nMismatch, comparisons;
  wake_event_control DUT (.clk(clk), .nrst(nrst), .nporRst(nporRst), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .linkUp(linkUp), .rxValid(rxValid), .rxData(rxData),
    .rxFirst(rxFirst), .rxGoodEnd(rxGoodEnd), .remoteWakeFrame(remoteWakeFrame),
    .cfgPmEnable(cfgPmEnable), .cfgWolEnable(cfgWolEnable), .pmEventClear(pmEventClear),
    .pmEventStatus(pmEventStatus), .irq(irq));
  wec_rx_model model (.clk(clk), .linkUp(linkUp), .rxValid(rxValid), .rxData(rxData),
    .rxFirst(rxFirst), .rxGoodEnd(rxGoodEnd), .remoteWakeFrame(remoteWakeFrame));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts, verdict, end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait ran out
  task automatic hang(input int n);
    if (n >= 64) begin
      nMismatch++;
      print_verdict();
    end
  endtask
  // register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    bready <= 1'b0;
    hang(n);
    `CHK("bresp", er, bresp)
  endtask
  // register read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    rready <= 1'b0;
    hang(n);
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask
  // power management side clears the event
  task automatic clr_pme();
    @(posedge clk);
    pmEventClear <= 1'b1;
    @(posedge clk);
    pmEventClear <= 1'b0;
  endtask
  // crc16 msb first, used to build the stored pattern value
  function automatic logic [15:0] crc_of(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ 16'h8005) : {c[14:0], 1'b0};
    return c;
  endfunction
  // main sequence
  initial begin
    {nrst, nporRst, awvalid, wvalid, bready, arvalid, rready, pmEventClear} = '0;
    {ce, cfgPmEnable, cfgWolEnable, wstrb} = 7'h7F;
    {awaddr, araddr, wdata} = '0;
    nMismatch = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    nporRst <= 1'b1;
    rd(8'h68, 32'h00000200, 2'h0);
    rd(8'h94, 32'h00000000, 2'h2);
    wr(8'h94, 32'hFFFFFFFF, 2'h2);
    $display("test reset done");
    wr(8'h68, 32'h00030100, 2'h0);
    model.set_link(1'b1);
    rd(8'h68, 32'h00030101, 2'h0);
    `CHK("pme", 1'b1, pmEventStatus)
    wr(8'h68, 32'h00030101, 2'h0);
    rd(8'h68, 32'h00030100, 2'h0);
    clr_pme();
    wr(8'h68, 32'h00010100, 2'h0);
    model.set_link(1'b0);
    rd(8'h68, 32'h00010100, 2'h0);
    `CHK("pme", 1'b0, pmEventStatus)
    wr(8'h68, 32'h00020100, 2'h0);
    model.set_link(1'b1);
    model.set_link(1'b0);
    rd(8'h68, 32'h00020101, 2'h0);
    $display("test link done");
    clr_pme();
    wr(8'h8C, 32'h00000002, 2'h0);
    wr(8'h88, 32'h0000000F, 2'h0);
    wr(8'h68, 32'h00000201, 2'h0);
    model.remote_pulse();
    rd(8'h68, 32'h00000202, 2'h0);
    `CHK("pme", 1'b1, pmEventStatus)
    rd(8'h88, 32'h0000000A, 2'h0);
    `CHK("irq", 1'b1, irq)
    wr(8'h88, 32'h00000002, 2'h0);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    wr(8'h68, 32'h00000002, 2'h0);
    rd(8'h68, 32'h00000000, 2'h0);
    $display("test remote done");
    // pattern two: offset 2, four masked bytes, all-ones start value
    pat = '{default: 32'h00000000};
    pat[0] = 32'h12345678;
    pat[5] = 32'h0000000F;
    crc = 16'hFFFF;
    for (int i = 2; i < 6; i++) crc = crc_of(crc, frm[i]);
    pat[9] = {crc, 16'h0002};
    for (int i = 0; i < 25; i++) wr(8'h70, pat[i], 2'h0);
    rd(8'h70, 32'h12345678, 2'h0);
    clr_pme();
    wr(8'h68, 32'h40000400, 2'h0);
    model.send_frame(frm);
    repeat (3) @(posedge clk);
    rd(8'h68, 32'h40000400, 2'h0);
    `CHK("pme", 1'b0, pmEventStatus)
    wr(8'h68, 32'h50000400, 2'h0);
    model.send_frame(frm);
    repeat (3) @(posedge clk);
    rd(8'h68, 32'h50000404, 2'h0);
    `CHK("pme", 1'b1, pmEventStatus)
    wr(8'h68, 32'h50000400, 2'h0);
    rd(8'h68, 32'h50000404, 2'h0);
    // same pattern with an all-zeros start value, flag cleared by a one first
    crc = 16'h0000;
    for (int i = 2; i < 6; i++) crc = crc_of(crc, frm[i]);
    pat[9] = {crc, 16'h0002};
    for (int i = 0; i < 25; i++) wr(8'h70, pat[i], 2'h0);
    wr(8'h68, 32'h10000404, 2'h0);
    rd(8'h68, 32'h10000400, 2'h0);
    clr_pme();
    model.send_frame(frm);
    repeat (3) @(posedge clk);
    rd(8'h68, 32'h10000404, 2'h0);
    `CHK("pme", 1'b1, pmEventStatus)
    $display("test pattern done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h68, 32'h00000204, 2'h0);
    `CHK("pme", 1'b1, pmEventStatus)
    @(posedge clk);
    nporRst <= 1'b0;
    repeat (2) @(posedge clk);
    nporRst <= 1'b1;
    rd(8'h68, 32'h00000200, 2'h0);
    `CHK("pme", 1'b0, pmEventStatus)
    // clock enable low: a remote wake pulse must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    model.remote_pulse();
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h68, 32'h00000200, 2'h0);
    `CHK("pme", 1'b0, pmEventStatus)
    // power-up reset with one config bit off: remote wake enable defaults to 0
    @(posedge clk);
    nporRst <= 1'b0;
    cfgWolEnable <= 1'b0;
    repeat (2) @(posedge clk);
    nporRst <= 1'b1;
    rd(8'h68, 32'h00000000, 2'h0);
    $display("test resets done");
    print_verdict();
  end
endmodule
